// File: dls_pkg.sv
package dls_pkg;
   // register byte addresses
   localparam logic [3:0] ADDR_CFG0 = 4'h0;
   localparam logic [3:0] ADDR_CFG1 = 4'h1;
   localparam logic [3:0] ADDR_STAT0 = 4'h2;
   localparam logic [3:0] ADDR_STAT1 = 4'h3;
   // config field positions
   localparam int CFG_PWR = 0;
   localparam int CFG_BIST_LO = 1;
   localparam int CFG_SPD_LO = 3;
   localparam int CFG_RATE = 5;
   localparam int CFG_ROE_LO = 6;
   // config after reset: power off, self-test off, drivers off, full rate
   localparam logic [7:0] CFG_RESET = 8'h00;
   // status field positions
   localparam int ST_LINK_OK = 0;
   localparam int ST_TRACK = 1;
   localparam int ST_CFG_BAD = 2;
   localparam int ST_COMPARE = 3;
   localparam int ST_LOOP_ERR = 4;
   // speed range codes and self-test enable code
   localparam logic [1:0] SPD_LOW = 2'h0;
   localparam logic [1:0] SPD_MID = 2'h1;
   localparam logic [1:0] SPD_HIGH = 2'h2;
   localparam logic [1:0] BIST_ON = 2'h2;
   localparam logic RATE_HALF = 1'b1;
   // clock period in ns, other timing in recovered character clocks
   localparam int CLK_PERIOD_NS = 100;
   localparam int RANGE_PERIOD = 4096;
   localparam int IDLE_CHARS_MAX = 6;
   localparam int ERR_EXCESS = 16;
   // pattern generator
   localparam logic [8:0] LFSR_SEED = 9'h1FF;
   localparam logic [2:0] CODE_LOOP_OK = 3'h2;
   localparam logic [2:0] CODE_LOOP_ERR = 3'h4;
   typedef enum logic [1:0] {BIST_START, BIST_AWAIT, BIST_COMPARE} dls_bist_t;
endpackage : dls_pkg

// File: dls_link_status.sv
// Overview of operation
// - fault low while tracking training clock
// - lock within one sampling period, then high
// - sampling period is 4096 character clocks
// - three speed bands, half rate reserved lowest
// - power latch zero disables channel recovery
// - disabled channel shows constant link fault
// - out of range follows training clock
// - retime and retransmit recovered data
// - drivers enabled separately; both off powers down
// - reset disables all reclocker drivers
// - ten bit character plus status bit
// - self-test runs 511 character LFSR
// - compare characters, report on status bits
// - 010b or 100b marks loop completion
// - errors exceed matches by 16 aborts
// - loss of lock forces start state
// - reset disables self-test on both channels
// - link valid only when all checks qualify
// - fault after seven characters without transitions
`timescale 1ns/100ps
`default_nettype none
module dls_link_status (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic [1:0][9:0] rxChar,
   input wire logic [1:0] amplitudeOk,
   input wire logic [1:0] refClockOk,
   input wire logic [1:0] freqInRange,
   input wire logic [1:0] lockToReferenceControl,
   input wire logic [1:0] pllLocked,
   output logic [1:0] linkFaultN,
   output logic [1:0][9:0] rxParallelData,
   output logic [1:0] selftestStatusBit,
   output logic [1:0][9:0] reclockChar,
   output logic [1:0][1:0] reclockDriverEn,
   output logic [1:0] rxChannelPowerEnable,
   output logic [1:0][1:0] speedRangeSelect,
   output logic [1:0] trainingRateSelect,
   output logic [1:0] trackTraining
);
   logic [1:0][7:0] cfg_r;
   logic [1:0][7:0] cfg_nxt;
   logic [7:0] rdData_r;
   logic [7:0] rdData_nxt;
   logic [1:0][7:0] status;

   // configuration writes and registered read data
   always_comb begin
      cfg_nxt = cfg_r;
      rdData_nxt = 8'h00;
      if (regWr && regAddr == dls_pkg::ADDR_CFG0) begin
         cfg_nxt[0] = regWrData;
      end
      if (regWr && regAddr == dls_pkg::ADDR_CFG1) begin
         cfg_nxt[1] = regWrData;
      end
      if (regRd) begin
         unique case (regAddr)
            dls_pkg::ADDR_CFG0: rdData_nxt = cfg_r[0];
            dls_pkg::ADDR_CFG1: rdData_nxt = cfg_r[1];
            dls_pkg::ADDR_STAT0: rdData_nxt = status[0];
            dls_pkg::ADDR_STAT1: rdData_nxt = status[1];
            default: rdData_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_r <= {2{dls_pkg::CFG_RESET}};
         rdData_r <= 8'h00;
      end else begin
         cfg_r <= cfg_nxt;
         rdData_r <= rdData_nxt;
      end
   end

   assign regRdData = rdData_r;

   for (genvar ch = 0; ch < 2; ch++) begin : gChan
      logic enable;
      logic [1:0] bistEn;
      logic [1:0] spd;
      logic rate;
      logic cfgBad;
      logic [11:0] rangeCnt_r;
      logic [11:0] rangeCnt_nxt;
      logic track_r;
      logic track_nxt;
      logic lastBit_r;
      logic lastBit_nxt;
      logic [2:0] idleCnt_r;
      logic [2:0] idleCnt_nxt;
      logic linkOk_r;
      logic linkOk_nxt;
      logic [9:0] recl_r;
      logic [9:0] recl_nxt;
      dls_pkg::dls_bist_t st_r;
      dls_pkg::dls_bist_t st_nxt;
      logic [8:0] lfsr_r;
      logic [8:0] lfsr_nxt;
      logic [8:0] lfsrStep;
      logic [4:0] errBal_r;
      logic [4:0] errBal_nxt;
      logic loopErr_r;
      logic loopErr_nxt;
      logic [2:0] code_r;
      logic [2:0] code_nxt;
      logic [9:0] data_r;
      logic [9:0] data_nxt;
      logic statBit_r;
      logic statBit_nxt;

      assign enable = cfg_r[ch][dls_pkg::CFG_PWR];
      assign bistEn = cfg_r[ch][dls_pkg::CFG_BIST_LO +: 2];
      assign spd = cfg_r[ch][dls_pkg::CFG_SPD_LO +: 2];
      assign rate = cfg_r[ch][dls_pkg::CFG_RATE];
      // half rate in lowest band is reserved
      assign cfgBad = (spd == dls_pkg::SPD_LOW) && (rate == dls_pkg::RATE_HALF);
      assign lfsrStep = {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};

      // range control, transition density and link qualification
      always_comb begin
         rangeCnt_nxt = rangeCnt_r + 12'h001;
         track_nxt = track_r;
         lastBit_nxt = rxChar[ch][9];
         idleCnt_nxt = idleCnt_r;
         linkOk_nxt = 1'b0;
         if (rangeCnt_r == 12'(dls_pkg::RANGE_PERIOD - 1)) begin
            track_nxt = !freqInRange[ch];
         end
         if (rxChar[ch] == {10{lastBit_r}}) begin
            if (idleCnt_r <= 3'(dls_pkg::IDLE_CHARS_MAX)) begin
               idleCnt_nxt = idleCnt_r + 3'h1;
            end
         end else begin
            idleCnt_nxt = 3'h0;
         end
         linkOk_nxt = enable && amplitudeOk[ch] && refClockOk[ch] && !lockToReferenceControl[ch]
            && !track_r && !cfgBad && idleCnt_r <= 3'(dls_pkg::IDLE_CHARS_MAX);
         if (!enable) begin
            rangeCnt_nxt = 12'h000;
            track_nxt = 1'b1;
            idleCnt_nxt = 3'h0;
            linkOk_nxt = 1'b0;
         end
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            rangeCnt_r <= 12'h000;
            track_r <= 1'b1;
            lastBit_r <= 1'b0;
            idleCnt_r <= 3'h0;
            linkOk_r <= 1'b0;
         end else begin
            rangeCnt_r <= rangeCnt_nxt;
            track_r <= track_nxt;
            lastBit_r <= lastBit_nxt;
            idleCnt_r <= idleCnt_nxt;
            linkOk_r <= linkOk_nxt;
         end
      end

      // reclocker path, held idle when both drivers are off
      always_comb begin
         recl_nxt = 10'h000;
         if (enable && cfg_r[ch][dls_pkg::CFG_ROE_LO +: 2] != 2'h0) begin
            recl_nxt = rxChar[ch];
         end
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            recl_r <= 10'h000;
         end else begin
            recl_r <= recl_nxt;
         end
      end

      // pattern checker state machine
      always_comb begin
         st_nxt = st_r;
         lfsr_nxt = lfsr_r;
         errBal_nxt = errBal_r;
         loopErr_nxt = loopErr_r;
         code_nxt = 3'h0;
         unique case (st_r)
            dls_pkg::BIST_START: begin
               lfsr_nxt = dls_pkg::LFSR_SEED;
               errBal_nxt = 5'h00;
               st_nxt = dls_pkg::BIST_AWAIT;
            end
            dls_pkg::BIST_AWAIT: begin
               if (rxChar[ch] == {lfsr_r, ^lfsr_r}) begin
                  st_nxt = dls_pkg::BIST_COMPARE;
                  lfsr_nxt = lfsrStep;
                  loopErr_nxt = 1'b0;
                  errBal_nxt = 5'h00;
               end
            end
            dls_pkg::BIST_COMPARE: begin
               lfsr_nxt = lfsrStep;
               if (rxChar[ch] != {lfsr_r, ^lfsr_r}) begin
                  errBal_nxt = errBal_r + 5'h01;
                  loopErr_nxt = 1'b1;
               end else if (errBal_r != 5'h00) begin
                  errBal_nxt = errBal_r - 5'h01;
               end
               if (lfsrStep == dls_pkg::LFSR_SEED) begin
                  code_nxt = loopErr_nxt ? dls_pkg::CODE_LOOP_ERR
                     : dls_pkg::CODE_LOOP_OK;
                  loopErr_nxt = 1'b0;
               end
               if (errBal_nxt >= 5'(dls_pkg::ERR_EXCESS)) begin
                  st_nxt = dls_pkg::BIST_AWAIT;
                  lfsr_nxt = dls_pkg::LFSR_SEED;
                  errBal_nxt = 5'h00;
                  code_nxt = 3'h0;
               end
            end
         endcase
         if (bistEn != dls_pkg::BIST_ON || !enable || !pllLocked[ch]) begin
            st_nxt = dls_pkg::BIST_START;
            code_nxt = 3'h0;
         end
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            st_r <= dls_pkg::BIST_START;
            lfsr_r <= dls_pkg::LFSR_SEED;
            errBal_r <= 5'h00;
            loopErr_r <= 1'b0;
            code_r <= 3'h0;
         end else begin
            st_r <= st_nxt;
            lfsr_r <= lfsr_nxt;
            errBal_r <= errBal_nxt;
            loopErr_r <= loopErr_nxt;
            code_r <= code_nxt;
         end
      end

      // parallel output; loop codes overlay status bit and data[1:0]
      always_comb begin
         data_nxt = rxChar[ch];
         statBit_nxt = 1'b0;
         if (code_nxt != 3'h0) begin
            statBit_nxt = code_nxt[2];
            data_nxt[0] = code_nxt[1];
            data_nxt[1] = code_nxt[0];
         end
         if (!enable) begin
            data_nxt = 10'h000;
         end
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            data_r <= 10'h000;
            statBit_r <= 1'b0;
         end else begin
            data_r <= data_nxt;
            statBit_r <= statBit_nxt;
         end
      end

      assign status[ch] = {3'h0, loopErr_r, st_r == dls_pkg::BIST_COMPARE, cfgBad, track_r,
         linkOk_r};
      assign linkFaultN[ch] = linkOk_r;
      assign rxParallelData[ch] = data_r;
      assign selftestStatusBit[ch] = statBit_r;
      assign reclockChar[ch] = recl_r;
      assign reclockDriverEn[ch] = cfg_r[ch][dls_pkg::CFG_ROE_LO +: 2];
      assign rxChannelPowerEnable[ch] = enable;
      assign speedRangeSelect[ch] = spd;
      assign trainingRateSelect[ch] = rate;
      assign trackTraining[ch] = track_r;
   end
endmodule : dls_link_status
`default_nettype wire

// File: dls_link_status_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module dls_link_status_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0][9:0] rxChar,
   input wire logic [1:0] amplitudeOk,
   input wire logic [1:0] refClockOk,
   input wire logic [1:0] lockToReferenceControl,
   input wire logic [1:0] linkFaultN,
   input wire logic [1:0][9:0] rxParallelData,
   input wire logic [1:0] selftestStatusBit,
   input wire logic [1:0][9:0] reclockChar,
   input wire logic [1:0][1:0] reclockDriverEn,
   input wire logic [1:0] rxChannelPowerEnable,
   input wire logic [1:0] trackTraining
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // fault causes on channel a
   off_fault_a: assert property (
      !rxChannelPowerEnable[0] |=> !linkFaultN[0] && rxParallelData[0] == '0)
      else $error("disabled channel not faulted");
   track_fault_a: assert property (trackTraining[0] [*2] |-> !linkFaultN[0])
      else $error("fault missing while tracking");
   lref_fault_a: assert property (lockToReferenceControl[0] |=> !linkFaultN[0])
      else $error("fault missing under reference lock");
   amp_fault_a: assert property (!amplitudeOk[0] |=> !linkFaultN[0])
      else $error("fault missing on low amplitude");
   refclk_fault_a: assert property (!refClockOk[0] |=> !linkFaultN[0])
      else $error("fault missing without reference");
   idle_fault_a: assert property (
      (rxChar[0] == 10'h000) [*8] |-> ##[1:2] !linkFaultN[0])
      else $error("fault missing on idle line");
   // reclocked path, status overlay and config cleared by reset
   rclk_off_a: assert property (reclockDriverEn[0] == 2'h0 |=> reclockChar[0] == '0)
      else $error("reclocked data with drivers off");
   rclk_on_a: assert property (
      rxChannelPowerEnable[0] && reclockDriverEn[0] != 2'h0
      |=> reclockChar[0] == $past(rxChar[0]))
      else $error("reclocked data wrong");
   loop_code_a: assert property (
      selftestStatusBit[0] |-> rxParallelData[0][1:0] == 2'h0)
      else $error("bad loop code");
   reset_cfg_a: assert property (
      $fell(rst) |-> reclockDriverEn == '0 && rxChannelPowerEnable == 2'h0)
      else $error("config not cleared by reset");
endmodule : dls_link_status_asserts
`default_nettype wire

// File: dls_tx_model.sv
`timescale 1ns/100ps
`default_nettype none
module dls_tx_model (
   input wire logic clk,
   input wire logic [1:0] mode,
   output logic [9:0] chr
);
   logic [8:0] lfsr;
   initial begin
      lfsr = dls_pkg::LFSR_SEED;
      chr = 10'h155;
   end
   // 0 busy data, 1 idle, 2 test pattern, 3 inverted pattern
   always @(posedge clk) begin
      lfsr <= {lfsr[7:0], lfsr[8] ^ lfsr[4]};
      case (mode)
         2'h0: chr <= chr[0] ? 10'h2AA : 10'h155;
         2'h1: chr <= 10'h000;
         2'h2: chr <= {lfsr, ^lfsr};
         default: chr <= ~{lfsr, ^lfsr};
      endcase
   end
endmodule : dls_tx_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk, rst, regWr, regRd, hit;
   logic [3:0] regAddr;
   logic [7:0] regWrData, regRdData;
   wire logic [1:0][9:0] rxChar;
   logic [1:0][9:0] rxParallelData, reclockChar;
   logic [1:0] amplitudeOk, refClockOk, freqInRange, lockToReferenceControl, pllLocked;
   logic [1:0] linkFaultN, selftestStatusBit, rxChannelPowerEnable, trainingRateSelect;
   logic [1:0] trackTraining, mode0, mode1;
   logic [1:0][1:0] reclockDriverEn, speedRangeSelect;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   dls_tx_model m0 (.clk(clk), .mode(mode0), .chr(rxChar[0]));
   dls_tx_model m1 (.clk(clk), .mode(mode1), .chr(rxChar[1]));
   dls_link_status dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxChar(rxChar),
      .amplitudeOk(amplitudeOk), .refClockOk(refClockOk), .freqInRange(freqInRange),
      .lockToReferenceControl(lockToReferenceControl), .pllLocked(pllLocked),
      .linkFaultN(linkFaultN), .rxParallelData(rxParallelData),
      .selftestStatusBit(selftestStatusBit), .reclockChar(reclockChar),
      .reclockDriverEn(reclockDriverEn), .rxChannelPowerEnable(rxChannelPowerEnable),
      .speedRangeSelect(speedRangeSelect), .trainingRateSelect(trainingRateSelect),
      .trackTraining(trackTraining));
   // clock and hang limit
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task print_verdict;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task chk(input logic [9:0] g, input logic [9:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdData & m, e);
   endtask : rd
   // loop code on the last pattern character of channel a, then the seed character
   task waitc(input logic [2:0] c);
      logic seen;
      hit = 1'b0;
      seen = 1'b0;
      repeat (1100) begin
         @(posedge clk);
         #1 if (seen && rxParallelData[0] === 10'h3FF)
            hit = 1'b1;
         seen = {selftestStatusBit[0], rxParallelData[0][0], rxParallelData[0][1]} === c
            && rxParallelData[0][9:2] === 8'h7F;
      end
      chk(hit, 1'b1);
   endtask : waitc
   initial begin
      rst = 1'b1;
      {regWr, regRd, regAddr, regWrData, mode0, mode1, lockToReferenceControl} = '0;
      {amplitudeOk, refClockOk, freqInRange, pllLocked} = '1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(4'h0, 8'h00, 8'hFF);
      rd(4'h2, 8'h02, 8'hFF);
      wr(4'h5, 8'hFF);
      rd(4'h5, 8'h00, 8'hFF);
      wr(4'h1, 8'h21);
      rd(4'h3, 8'h06, 8'hFF);
      wr(4'h0, 8'hD5);
      rd(4'h0, 8'hD5, 8'hFF);
      chk(speedRangeSelect[0], 10'(dls_pkg::SPD_HIGH));
      chk(speedRangeSelect[1], 10'(dls_pkg::SPD_LOW));
      chk(trainingRateSelect, 10'h002);
      chk(reclockDriverEn[0], 10'h003);
      chk(rxChannelPowerEnable, 10'h003);
      repeat (4000) @(posedge clk);
      #1 chk(linkFaultN[0], 1'b0);
      repeat (100) @(posedge clk);
      #1 chk(linkFaultN, 2'h1);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         amplitudeOk[0] <= i != 0;
         refClockOk[0] <= i != 1;
         lockToReferenceControl[0] <= i == 2;
         repeat (3) @(posedge clk);
         #1 chk(linkFaultN[0], 1'b0);
      end
      @(posedge clk);
      lockToReferenceControl[0] <= 1'b0;
      mode0 <= 2'h1;
      repeat (10) @(posedge clk);
      #1 chk(linkFaultN[0], 1'b0);
      @(posedge clk);
      mode0 <= 2'h0;
      repeat (3) @(posedge clk);
      #1 chk(linkFaultN[0], 1'b1);
      @(posedge clk);
      mode0 <= 2'h2;
      waitc(3'b010);
      rd(4'h2, 8'h08, 8'h08);
      @(posedge clk);
      mode0 <= 2'h3;
      @(posedge clk);
      mode0 <= 2'h2;
      waitc(3'b100);
      @(posedge clk);
      mode0 <= 2'h3;
      repeat (20) @(posedge clk);
      rd(4'h2, 8'h00, 8'h08);
      @(posedge clk);
      mode0 <= 2'h2;
      waitc(3'b010);
      @(posedge clk);
      pllLocked[0] <= 1'b0;
      rd(4'h2, 8'h00, 8'h08);
      wr(4'h0, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk(linkFaultN[0], 1'b0);
      chk(rxParallelData[0], 10'h000);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(4'h1, 8'h00, 8'hFF);
      print_verdict();
   end
endmodule : tb_top
bind dls_link_status dls_link_status_asserts chk_i (.clk(clk), .rst(rst), .rxChar(rxChar),
   .amplitudeOk(amplitudeOk), .refClockOk(refClockOk),
   .lockToReferenceControl(lockToReferenceControl), .linkFaultN(linkFaultN),
   .rxParallelData(rxParallelData), .selftestStatusBit(selftestStatusBit),
   .reclockChar(reclockChar), .reclockDriverEn(reclockDriverEn),
   .rxChannelPowerEnable(rxChannelPowerEnable), .trackTraining(trackTraining));
`default_nettype wire
